// [arps_consts.vh]
// Constants for the recloser protection sequencer.
// Assumes inclusion by its bare name from the design files.
`ifndef ARPS_CONSTS_VH
`define ARPS_CONSTS_VH
// Register indices.
`define ARPS_A_CTRL      4'h0
`define ARPS_A_SHOTS     4'h1
`define ARPS_A_HCT       4'h2
`define ARPS_A_CLP       4'h3
`define ARPS_A_RESET_T   4'h4
`define ARPS_A_DEAD_T    4'h5
`define ARPS_A_CURVE     4'h6
`define ARPS_A_TDM       4'h7
`define ARPS_A_ADDER     4'h8
`define ARPS_A_MINRESP   4'h9
`define ARPS_A_DT2       4'hA
`define ARPS_A_DT3       4'hB
`define ARPS_A_CLP_T     4'hC
`define ARPS_A_STATUS    4'hD
`define ARPS_A_MTA       4'hE
// Control bits.
`define ARPS_C_RECL_EN   0
`define ARPS_C_SEQCO_EN  1
`define ARPS_C_INR_BLK   2
`define ARPS_C_INR_DET   3
`define ARPS_C_SEF_EN    4
// Limits and widths.
`define ARPS_MAX_SHOTS   3'h4
`define ARPS_MAX_HCT     3'h4
`define ARPS_MAX_CLPM    4'hA
`define ARPS_CURVE_LAST  6'h3A
`define ARPS_CURVE_USER0 6'h37
`define ARPS_ANG_QTR     9'h05A
`define ARPS_ANG_FULL    10'h168
`define ARPS_TDM_ONE     16'h0064
`define ARPS_T_ONE       32'h0000_0001
`define ARPS_ZERO32      32'h0000_0000
// Reset values of the settings.
`define ARPS_RST_CTRL    5'h01
`define ARPS_RST_FAST    3'h2
`define ARPS_RST_TIME    32'h0000_03E8
`define ARPS_RST_CURVE   6'h01
`define ARPS_RST_DT2     32'h0000_0064
`endif

// [arps_op_time.v]
// Operate time adjuster for the inverse-time element.
// Assumes base curve time in ticks and multiplier in hundredths (100 = unity).
`timescale 1ns/1ns
`default_nettype none
`include "arps_consts.vh"
module arps_op_time
(
    input  wire        sys_clk,
    input  wire        rst_n,
    input  wire [31:0] base_time,
    input  wire [15:0] tdm,
    input  wire [31:0] adder,
    input  wire [31:0] min_resp,
    output reg  [31:0] op_time
);
    wire [47:0] scaled_w = base_time * tdm;
    wire [47:0] scaled_q = scaled_w / {32'h0, `ARPS_TDM_ONE};
    // Saturate rather than wrap, so a huge multiplier can only slow the trip.
    wire [31:0] scaled   = (scaled_q > 48'h0000_FFFF_FFFF) ? 32'hFFFF_FFFF : scaled_q[31:0];
    wire [32:0] sum      = {1'b0, scaled} + {1'b0, adder};
    wire [31:0] added    = sum[32] ? 32'hFFFF_FFFF : sum[31:0];
    // Scale first, then add, then clamp to the floor; the order matters.
    always @(posedge sys_clk)
    begin
        if (!rst_n)
            op_time <= `ARPS_ZERO32;
        else
            op_time <= (added < min_resp) ? min_resp : added;
    end
endmodule
`default_nettype wire

// [arps_seq.v]
// Recloser protection sequencer: shot counting, element choice and lockout.
// Assumes synchronous inputs on sys_clk; currents and pickup levels come from the measuring front end.
`timescale 1ns/1ns
`default_nettype none
`include "arps_consts.vh"
module arps_seq
(
    input  wire        sys_clk,
    input  wire        rst_n,
    input  wire [3:0]  reg_addr,
    input  wire [31:0] reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [31:0] reg_rdata,
    input  wire [31:0] phase_current,
    input  wire [31:0] ground_current,
    input  wire [31:0] phase_pickup,
    input  wire [31:0] ground_pickup,
    input  wire [31:0] hct_level,
    input  wire        second_harmonic_high,
    input  wire [8:0]  residual_angle,
    input  wire [31:0] curve_base_time,
    input  wire        ext_close,
    output reg         trip_cmd,
    output reg         close_cmd,
    output reg         lockout,
    output reg  [5:0]  curve_sel,
    output reg         high_current_trip_flag
);
    ////////////////////////////////////////////////////////////////////////////
    localparam ST_IDLE  = 5'h01;
    localparam ST_TIME  = 5'h02;
    localparam ST_DEAD  = 5'h04;
    localparam ST_RESET = 5'h08;
    localparam ST_LOCK  = 5'h10;

    reg [4:0]  ctrl_r;
    reg [2:0]  shots_tot_r;
    reg [2:0]  shots_fast_r;
    reg [2:0]  hct_ph_r;
    reg [2:0]  hct_gd_r;
    reg [3:0]  clpm_ph_r;
    reg [3:0]  clpm_gd_r;
    reg [31:0] reset_t_r;
    reg [31:0] dead_t_r;
    reg [15:0] tdm_r;
    reg [31:0] adder_r;
    reg [31:0] minresp_r;
    reg [31:0] dt2_r;
    reg [31:0] dt3_r;
    reg [31:0] clp_t_r;
    reg [8:0]  mta_r;
    reg [4:0]  st_r;
    reg [2:0]  shot_r;
    reg [2:0]  hct_used_r;
    reg [31:0] tmr_r;
    reg [31:0] dt_tmr_r;
    reg        cold_r;
    reg [31:0] cold_tmr_r;
    reg        dly_r;
    wire [31:0] op_time;

    arps_op_time u_op
    (
        .sys_clk   (sys_clk),
        .rst_n     (rst_n),
        .base_time (curve_base_time),
        .tdm       (tdm_r),
        .adder     (adder_r),
        .min_resp  (minresp_r),
        .op_time   (op_time)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Count settings out of range are clamped and bad curve codes ignored, so a bad write cannot break counting.
    always @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            ctrl_r       <= `ARPS_RST_CTRL;
            shots_tot_r  <= `ARPS_MAX_SHOTS;
            shots_fast_r <= `ARPS_RST_FAST;
            hct_ph_r     <= 3'h0;
            hct_gd_r     <= 3'h0;
            clpm_ph_r    <= 4'h0;
            clpm_gd_r    <= 4'h0;
            reset_t_r    <= `ARPS_RST_TIME;
            dead_t_r     <= `ARPS_RST_TIME;
            curve_sel    <= `ARPS_RST_CURVE;
            tdm_r        <= `ARPS_TDM_ONE;
            adder_r      <= `ARPS_ZERO32;
            minresp_r    <= `ARPS_ZERO32;
            dt2_r        <= `ARPS_RST_DT2;
            dt3_r        <= `ARPS_T_ONE;
            clp_t_r      <= `ARPS_RST_TIME;
            mta_r        <= 9'h000;
        end
        else if (reg_wr)
        begin
            case (reg_addr)
            `ARPS_A_CTRL:    ctrl_r <= reg_wdata[4:0];
            `ARPS_A_SHOTS:
            begin
                shots_tot_r  <= (reg_wdata[2:0] > `ARPS_MAX_SHOTS) ? `ARPS_MAX_SHOTS
                                : reg_wdata[2:0];
                shots_fast_r <= (reg_wdata[6:4] > `ARPS_MAX_SHOTS) ? `ARPS_MAX_SHOTS
                                : reg_wdata[6:4];
            end
            `ARPS_A_HCT:
            begin
                hct_ph_r <= (reg_wdata[2:0] > `ARPS_MAX_HCT) ? `ARPS_MAX_HCT
                            : reg_wdata[2:0];
                hct_gd_r <= (reg_wdata[6:4] > `ARPS_MAX_HCT) ? `ARPS_MAX_HCT
                            : reg_wdata[6:4];
            end
            `ARPS_A_CLP:
            begin
                clpm_ph_r <= (reg_wdata[3:0] > `ARPS_MAX_CLPM) ? `ARPS_MAX_CLPM
                             : reg_wdata[3:0];
                clpm_gd_r <= (reg_wdata[7:4] > `ARPS_MAX_CLPM) ? `ARPS_MAX_CLPM
                             : reg_wdata[7:4];
            end
            `ARPS_A_RESET_T: reset_t_r <= reg_wdata;
            `ARPS_A_DEAD_T:  dead_t_r  <= reg_wdata;
            `ARPS_A_CURVE:
                if (reg_wdata[5:0] != 6'h00 && reg_wdata[5:0] <= `ARPS_CURVE_LAST)
                    curve_sel <= reg_wdata[5:0];
            `ARPS_A_TDM:     tdm_r     <= reg_wdata[15:0];
            `ARPS_A_ADDER:   adder_r   <= reg_wdata;
            `ARPS_A_MINRESP: minresp_r <= reg_wdata;
            `ARPS_A_DT2:     dt2_r     <= reg_wdata;
            `ARPS_A_DT3:     dt3_r     <= reg_wdata;
            `ARPS_A_CLP_T:   clp_t_r   <= reg_wdata;
            `ARPS_A_MTA:     mta_r     <= reg_wdata[8:0];
            default: ;
            endcase
        end
    end

    always @(posedge sys_clk)
    begin
        if (!rst_n)
            reg_rdata <= `ARPS_ZERO32;
        else if (reg_rd)
        begin
            case (reg_addr)
            `ARPS_A_CTRL:    reg_rdata <= {27'h0, ctrl_r};
            `ARPS_A_SHOTS:   reg_rdata <= {25'h0, shots_fast_r, 1'b0, shots_tot_r};
            `ARPS_A_HCT:     reg_rdata <= {25'h0, hct_gd_r, 1'b0, hct_ph_r};
            `ARPS_A_CLP:     reg_rdata <= {24'h0, clpm_gd_r, clpm_ph_r};
            `ARPS_A_RESET_T: reg_rdata <= reset_t_r;
            `ARPS_A_DEAD_T:  reg_rdata <= dead_t_r;
            `ARPS_A_CURVE:   reg_rdata <= {25'h0, (curve_sel >= `ARPS_CURVE_USER0), curve_sel};
            `ARPS_A_TDM:     reg_rdata <= {16'h0, tdm_r};
            `ARPS_A_ADDER:   reg_rdata <= adder_r;
            `ARPS_A_MINRESP: reg_rdata <= minresp_r;
            `ARPS_A_DT2:     reg_rdata <= dt2_r;
            `ARPS_A_DT3:     reg_rdata <= dt3_r;
            `ARPS_A_CLP_T:   reg_rdata <= clp_t_r;
            `ARPS_A_STATUS:  reg_rdata <= {20'h0, cold_r, hct_used_r, shot_r, st_r};
            `ARPS_A_MTA:     reg_rdata <= {23'h0, mta_r};
            default:         reg_rdata <= `ARPS_ZERO32;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    wire recl_en  = ctrl_r[`ARPS_C_RECL_EN];
    wire seqco_en = ctrl_r[`ARPS_C_SEQCO_EN] & recl_en;
    wire inrush   = ctrl_r[`ARPS_C_INR_BLK] & ctrl_r[`ARPS_C_INR_DET]
                    & second_harmonic_high;
    // Pickups scaled by the cold-load multiplier; a zero multiplier means no cold mode.
    wire cold_ph  = cold_r & (clpm_ph_r != 4'h0);
    wire cold_gd  = cold_r & (clpm_gd_r != 4'h0);
    wire [35:0] pk_ph = cold_ph ? phase_pickup * clpm_ph_r : {4'h0, phase_pickup};
    wire [35:0] pk_gd = cold_gd ? ground_pickup * clpm_gd_r : {4'h0, ground_pickup};
    wire ph_over  = {4'h0, phase_current} > pk_ph;
    wire gd_raw   = {4'h0, ground_current} > pk_gd;
    // Directional check: residual angle within a quarter turn either side of torque angle.
    wire [9:0] ang_d  = ({1'b0, residual_angle} + `ARPS_ANG_FULL - {1'b0, mta_r})
                        % `ARPS_ANG_FULL;
    wire sef_ok   = ~ctrl_r[`ARPS_C_SEF_EN] | (ang_d <= {1'b0, `ARPS_ANG_QTR})
                    | (ang_d >= `ARPS_ANG_FULL - {1'b0, `ARPS_ANG_QTR});
    wire gd_over  = gd_raw & sef_ok;
    wire fault    = (ph_over | gd_over) & ~inrush;
    wire [2:0] hct_lim = ph_over ? hct_ph_r : hct_gd_r;
    wire hct_hit  = fault & (phase_current > hct_level | ground_current > hct_level)
                    & (hct_used_r < hct_lim);
    // A zero multiplier switches cold mode off, so it must not force the delayed element.
    wire fast     = (shot_r < shots_fast_r) & ~(ph_over ? cold_ph : cold_gd);
    wire last     = (shot_r + 3'h1 >= shots_tot_r) | ~recl_en;
    // Curve time from the adjuster, or the definite stages; third ignores restraint.
    wire dt2_ok   = ~second_harmonic_high;
    wire stage3   = (dt_tmr_r >= dt3_r) & fast;
    wire stage2   = (dt_tmr_r >= dt2_r) & dt2_ok;
    wire curve_to = (tmr_r >= op_time);

    ////////////////////////////////////////////////////////////////////////////
    always @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            st_r       <= ST_IDLE;
            shot_r     <= 3'h0;
            hct_used_r <= 3'h0;
            tmr_r      <= `ARPS_ZERO32;
            dt_tmr_r   <= `ARPS_ZERO32;
            trip_cmd   <= 1'b0;
            close_cmd  <= 1'b0;
            lockout    <= 1'b0;
            high_current_trip_flag <= 1'b0;
            dly_r      <= 1'b0;
        end
        else
        begin
            trip_cmd  <= 1'b0;
            close_cmd <= 1'b0;
            high_current_trip_flag <= 1'b0;
            case (st_r)
            ST_IDLE, ST_RESET:
            begin
                tmr_r <= tmr_r + `ARPS_T_ONE;
                if (st_r == ST_RESET && !fault && tmr_r >= reset_t_r)
                begin
                    st_r       <= ST_IDLE;
                    shot_r     <= 3'h0;
                    hct_used_r <= 3'h0;
                end
                if (fault)
                begin
                    st_r     <= ST_TIME;
                    tmr_r    <= `ARPS_ZERO32;
                    dt_tmr_r <= `ARPS_ZERO32;
                    dly_r    <= ~fast;
                end
            end
            ST_TIME:
            begin
                tmr_r    <= tmr_r + `ARPS_T_ONE;
                dt_tmr_r <= dt_tmr_r + `ARPS_T_ONE;
                if (hct_hit || (fault && (stage3 || stage2 || curve_to || fast)))
                begin
                    // High current has priority and trips at once.
                    trip_cmd <= 1'b1;
                    high_current_trip_flag <= hct_hit;
                    if (hct_hit)
                        hct_used_r <= hct_used_r + 3'h1;
                    tmr_r <= `ARPS_ZERO32;
                    if (last)
                    begin
                        st_r    <= ST_LOCK;
                        lockout <= 1'b1;
                    end
                    else
                    begin
                        st_r   <= ST_DEAD;
                        shot_r <= shot_r + 3'h1;
                    end
                end
                else if (!fault)
                begin
                    tmr_r <= `ARPS_ZERO32;
                    st_r  <= ST_RESET;
                    if (seqco_en && dly_r && !last)
                        shot_r <= shot_r + 3'h1;
                end
            end
            ST_DEAD:
            begin
                tmr_r <= tmr_r + `ARPS_T_ONE;
                if (tmr_r >= dead_t_r)
                begin
                    close_cmd <= 1'b1;
                    tmr_r     <= `ARPS_ZERO32;
                    st_r      <= ST_RESET;
                end
            end
            ST_LOCK:
            begin
                if (ext_close)
                begin
                    close_cmd  <= 1'b1;
                    lockout    <= 1'b0;
                    shot_r     <= 3'h0;
                    hct_used_r <= 3'h0;
                    tmr_r      <= `ARPS_ZERO32;
                    st_r       <= ST_RESET;
                end
            end
            default: st_r <= ST_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Cold mode starts at reset and on close after lockout, and ends once current stays low for restore time.
    always @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            cold_r     <= 1'b1;
            cold_tmr_r <= `ARPS_ZERO32;
        end
        else if (st_r == ST_LOCK && ext_close)
        begin
            cold_r     <= 1'b1;
            cold_tmr_r <= `ARPS_ZERO32;
        end
        else if (cold_r)
        begin
            if (ph_over || gd_raw)
                cold_tmr_r <= `ARPS_ZERO32;
            else if (cold_tmr_r >= clp_t_r)
                cold_r <= 1'b0;
            else
                cold_tmr_r <= cold_tmr_r + `ARPS_T_ONE;
        end
    end
endmodule
`default_nettype wire

// [arps_seq_chk.sv]
// Checker for the sequencer's command and setting outputs.
// Assumes it is bound to arps_seq and sees only its ports.
`timescale 1ns/1ns
`default_nettype none
`include "arps_consts.vh"
module arps_seq_chk
(
    input wire logic       sys_clk,
    input wire logic       rst_n,
    input wire logic [3:0] reg_addr,
    input wire logic       reg_wr,
    input wire logic       ext_close,
    input wire logic       trip_cmd,
    input wire logic       close_cmd,
    input wire logic       lockout,
    input wire logic [5:0] curve_sel,
    input wire logic       high_current_trip_flag
);
    default clocking dc @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);
    logic cwr_r;
    // A curve write is the only cause that may move the code.
    always @(posedge sys_clk)
    begin
        cwr_r <= reg_wr && (reg_addr == `ARPS_A_CURVE);
    end
    ////////////////////////////////////////////////////////////////////////////
    trip_pulse_a: assert property (trip_cmd |=> !trip_cmd)
        else $error("trip command wider than one cycle");
    close_pulse_a: assert property (close_cmd |=> !close_cmd)
        else $error("close command wider than one cycle");
    hct_flag_a: assert property (high_current_trip_flag |-> trip_cmd)
        else $error("high current flag without trip");
    curve_range_a: assert property (curve_sel != 6'h00 && curve_sel <= 6'h3A)
        else $error("curve code outside 1 to 58");
    curve_hold_a: assert property (!cwr_r |-> $stable(curve_sel))
        else $error("curve code moved without a write");
    lock_hold_a: assert property (lockout && !ext_close |=> lockout)
        else $error("lockout left without external close");
    lock_noclose_a: assert property (lockout && $past(lockout) && !$past(ext_close) |-> !close_cmd)
        else $error("automatic close during lockout");
    lock_notrip_a: assert property (lockout && $past(lockout) |-> !trip_cmd)
        else $error("trip issued while locked open");
    lock_release_a: assert property (lockout && ext_close |-> ##[1:4] !lockout)
        else $error("external close did not clear lockout");
    ////////////////////////////////////////////////////////////////////////////
    trip_c: cover property (trip_cmd);
    hct_c: cover property (high_current_trip_flag);
    lock_c: cover property ($rose(lockout));
endmodule
bind arps_seq arps_seq_chk u_arps_seq_chk
(
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .reg_addr(reg_addr),
    .reg_wr(reg_wr),
    .ext_close(ext_close),
    .trip_cmd(trip_cmd),
    .close_cmd(close_cmd),
    .lockout(lockout),
    .curve_sel(curve_sel),
    .high_current_trip_flag(high_current_trip_flag)
);
`default_nettype wire

// [arps_plant.sv]
// Switch mechanism and phase current front end model.
// Assumes one-cycle trip and close pulses on sys_clk.
`timescale 1ns/1ns
`default_nettype none
module arps_plant
(
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic        trip_cmd,
    input  wire logic        close_cmd,
    input  wire logic        ext_close,
    input  wire logic        fault_on,
    input  wire logic [31:0] fault_level,
    output var  logic [31:0] phase_current
);
    logic closed_r;
    // An open pole drops the current to 100, below pickup, so a trip really clears the fault.
    always @(posedge sys_clk)
    begin
        if (!rst_n)
            closed_r <= 1'b1;
        else if (trip_cmd)
            closed_r <= 1'b0;
        else if (close_cmd || ext_close)
            closed_r <= 1'b1;
    end
    always_comb
    begin
        phase_current = (closed_r && fault_on) ? fault_level : 32'h0000_0064;
    end
endmodule
`default_nettype wire

// [test_auto_recloser_protection_sequencer.sv]
// Self-checking bench for the recloser protection sequencer.
// Assumes arps_seq, its constants header and the plant model.
`timescale 1ns/1ns
`default_nettype none
`include "arps_consts.vh"
module test_auto_recloser_protection_sequencer;
    logic        sys_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [3:0]  reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic [31:0] phase_current;
    logic [31:0] pickup = 32'h0000_03E8;
    logic [31:0] hct_lvl = 32'h0000_1388;
    logic [31:0] base_t = 32'h0000_0028;
    logic [31:0] fault_level = 32'h0000_07D0;
    logic        fault_on = 1'b0;
    logic        second_harmonic_high = 1'b0;
    logic        ext_close = 1'b0;
    logic [31:0] gnd_i = 32'h0000_0000;
    logic [8:0]  res_ang = 9'h000;
    logic        trip_cmd;
    logic        close_cmd;
    logic        lockout;
    logic        high_current_trip_flag;
    logic [5:0]  curve_sel;
    int          n_mismatch = 0;
    int          n_checks = 0;
    arps_seq u_arps_seq
    (
        .sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .phase_current(phase_current),
        .ground_current(gnd_i), .phase_pickup(pickup),
        .ground_pickup(pickup), .hct_level(hct_lvl),
        .second_harmonic_high(second_harmonic_high), .residual_angle(res_ang),
        .curve_base_time(base_t), .ext_close(ext_close), .trip_cmd(trip_cmd),
        .close_cmd(close_cmd), .lockout(lockout), .curve_sel(curve_sel),
        .high_current_trip_flag(high_current_trip_flag)
    );
    arps_plant u_arps_plant
    (
        .sys_clk(sys_clk), .rst_n(rst_n), .trip_cmd(trip_cmd),
        .close_cmd(close_cmd), .ext_close(ext_close), .fault_on(fault_on),
        .fault_level(fault_level), .phase_current(phase_current)
    );
    always #5 sys_clk = ~sys_clk;
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
        n_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask
    task automatic step;
        @(posedge sys_clk);
        #1;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
    task automatic end_of_test;
        if (n_mismatch == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic cv(input logic [31:0] c, input logic [5:0] e);
        wr(`ARPS_A_CURVE, c);
        chk(curve_sel, e, "curve code");
    endtask
    task automatic s_curve;
        logic [31:0] d;
        chk(curve_sel, 6'h01, "curve after reset");
        cv(32'h0000_003A, 6'h3A);
        cv(32'h0000_0000, 6'h3A);
        cv(32'h0000_003B, 6'h3A);
        cv(32'h0000_0037, 6'h37);
        cv(32'h0000_0001, 6'h01);
        rd(4'hF, d);
        chk(d, 32'h0000_0000, "unmapped read");
    endtask
    // Count n trips; the first nf must be fast, the rest wait the curve.
    task automatic s_perm(input int n, input int nf);
        int t, k, c;
        int d [4];
        t = 0;
        k = 0;
        c = 0;
        fault_on <= 1'b1;
        repeat (2000)
        begin
            step;
            t++;
            if (close_cmd) t = 0;
            if (trip_cmd && k < 4)
            begin
                d[k] = t;
                k++;
            end
            if (lockout) break;
        end
        chk(k, n, "trip count");
        for (int i = 0; i < k; i++)
            chk(d[i] < 8, i < nf, "fast or delayed shot");
        chk(lockout, 1'b1, "no lockout");
        fault_on <= 1'b0;
        repeat (30)
        begin
            step;
            c += close_cmd;
        end
        chk(c, 0, "close while locked");
        @(posedge sys_clk);
        ext_close <= 1'b1;
        @(posedge sys_clk);
        ext_close <= 1'b0;
        repeat (5) step;
        chk(lockout, 1'b0, "lockout kept");
    endtask
    task automatic s_temp(input int gap);
        fault_on <= 1'b1;
        repeat (20)
        begin
            step;
            if (trip_cmd) break;
        end
        fault_on <= 1'b0;
        repeat (gap) step;
    endtask
    task automatic s_hct(input logic [31:0] cnt, input logic flag);
        int t;
        logic f;
        wr(`ARPS_A_HCT, cnt);
        fault_level <= 32'h0000_1F40;
        fault_on <= 1'b1;
        t = 0;
        f = 1'b0;
        repeat (20)
        begin
            step;
            t++;
            if (trip_cmd)
            begin
                f = high_current_trip_flag;
                break;
            end
        end
        chk(t < 8, 1'b1, "high current trip late");
        chk(f, flag, "high current flag");
        fault_on <= 1'b0;
        fault_level <= 32'h0000_07D0;
        repeat (250) step;
    endtask
    // Cold mode follows the close out of lockout; the phase multiplier is two.
    task automatic s_cold;
        int t, k;
        wr(`ARPS_A_CLP, 32'h0000_0002);
        fault_level <= 32'h0000_05DC;
        fault_on <= 1'b1;
        k = 0;
        repeat (30)
        begin
            step;
            k += trip_cmd;
        end
        chk(k, 0, "cold pickup not raised");
        fault_level <= 32'h0000_0BB8;
        t = 0;
        repeat (100)
        begin
            step;
            t++;
            if (trip_cmd) break;
        end
        chk(t >= 8 && t < 100, 1'b1, "cold trip not delayed");
        fault_on <= 1'b0;
        fault_level <= 32'h0000_07D0;
        wr(`ARPS_A_CLP, 32'h0000_0000);
        repeat (200) step;
    endtask
    // Earth current outside the directional zone must not trip; inside it must.
    task automatic s_sef;
        int k;
        wr(`ARPS_A_CTRL, 32'h0000_0011);
        res_ang <= 9'h0B4;
        gnd_i <= 32'h0000_07D0;
        k = 0;
        repeat (20)
        begin
            step;
            k += trip_cmd;
        end
        chk(k, 0, "earth trip outside zone");
        res_ang <= 9'h02D;
        repeat (20)
        begin
            step;
            k += trip_cmd;
        end
        chk(k, 1, "earth trip inside zone");
        gnd_i <= 32'h0000_0000;
        repeat (200) step;
    endtask
    // A delayed shot cleared downstream advances the count with no trip.
    task automatic s_coord;
        int k;
        logic [31:0] d;
        wr(`ARPS_A_CTRL, 32'h0000_0003);
        wr(`ARPS_A_SHOTS, 32'h0000_0004);
        fault_on <= 1'b1;
        k = 0;
        repeat (10)
        begin
            step;
            k += trip_cmd;
        end
        fault_on <= 1'b0;
        repeat (2) step;
        rd(`ARPS_A_STATUS, d);
        chk(k, 0, "coordination tripped");
        chk(d[7:5], 3'h1, "coordination count");
    endtask
    task automatic s_inrush;
        int k;
        wr(`ARPS_A_CTRL, 32'h0000_000D);
        second_harmonic_high <= 1'b1;
        fault_on <= 1'b1;
        k = 0;
        repeat (100)
        begin
            step;
            k += trip_cmd;
        end
        chk(k, 0, "inrush advanced the sequence");
        fault_on <= 1'b0;
        second_harmonic_high <= 1'b0;
        wr(`ARPS_A_CTRL, 32'h0000_0001);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (16) @(posedge sys_clk);
        rst_n <= 1'b1;
        step;
        s_curve;
        // Cold flag is set from reset; the multipliers already reset to zero and are written zero again.
        wr(`ARPS_A_CLP, 32'h0000_0000);
        wr(`ARPS_A_HCT, 32'h0000_0000);
        wr(`ARPS_A_SHOTS, 32'h0000_0024);
        wr(`ARPS_A_DEAD_T, 32'h0000_0014);
        wr(`ARPS_A_RESET_T, 32'h0000_0096);
        wr(`ARPS_A_TDM, 32'h0000_0064);
        wr(`ARPS_A_ADDER, 32'h0000_0000);
        wr(`ARPS_A_MINRESP, 32'h0000_0000);
        wr(`ARPS_A_DT2, 32'h0000_03E8);
        wr(`ARPS_A_DT3, 32'h0000_03E8);
        wr(`ARPS_A_CTRL, 32'h0000_0001);
        s_perm(4, 2);
        s_temp(250);
        s_perm(4, 2);
        s_temp(60);
        s_perm(3, 1);
        s_cold;
        s_hct(32'h0000_0011, 1'b1);
        s_hct(32'h0000_0000, 1'b0);
        s_inrush;
        s_sef;
        s_coord;
        end_of_test;
    end
    initial
    begin
        #300000;
        n_mismatch++;
        end_of_test;
    end
endmodule
`default_nettype wire
